// *** hw/pel_event_log.sv ***
`timescale 1ns/10ps
// Contract
// - entry holds code, date and time
// - distinct code per stage transition
// - remote read returns oldest unread, advances pointer
// - re-read last entry without advancing
// - local browse both ways, independent
// - masked events never enter log
// - capacity defaults to 200 entries
// - capacity settable 50 through 2000
// - capacity change empties the log
// - full log overwrites oldest entry
// - unpolled overflow marks newest entry
// - timestamps in whole milliseconds
// - local order oldest or newest first
// - fault value per-unit or primary
// - popup indication only when enabled
// - unsynchronized time flagged per entry
// - identifier channel then code, hide zero
module pel_event_log import pel_pkg::*; #(
	parameter int unsigned CYC_PER_MS = PEL_CYC_PER_MS
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	input  wire logic [7:0]        stage_start,
	input  wire logic [7:0]        stage_trip,
	input  wire logic [15:0]       fault_pu,
	input  wire logic [15:0]       fault_pri,
	input  wire logic              time_sync_in,
	output logic                   popup_indication
);
	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [10:0] idx_sub(logic [10:0] a, logic [10:0] b, logic [10:0] c);
		logic [11:0] t;
		t = {1'b0, a} - {1'b0, b};
		if (t[11]) begin
			t = t + {1'b0, c};
		end
		return t[10:0];
	endfunction : idx_sub
	function automatic logic [10:0] idx_add(logic [10:0] a, logic [10:0] b, logic [10:0] c);
		logic [11:0] t;
		t = {1'b0, a} + {1'b0, b};
		if (t >= {1'b0, c}) begin
			t = t - {1'b0, c};
		end
		return t[10:0];
	endfunction : idx_add
	function automatic logic [31:0] id_word(pel_entry_type e, logic v);
		logic [31:0] w;
		w                = {16'h0000, e.chan, e.code};
		w[PEL_ID_VALID]  = v;
		w[PEL_ID_OVF]    = e.ovf;
		w[PEL_ID_UNSYNC] = e.unsync;
		w[PEL_ID_SHOWCH] = (e.chan != 8'h00);
		return w;
	endfunction : id_word
	function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	////////////////////////////////////////////////////////////////////////////////
	// State
	pel_entry_type    mem [0:PEL_DEPTH-1];
	pel_entry_type    pop_entry_q, loc_entry_q, hold_q, new_entry;
	pel_rd_state_type rd_state_q;
	logic [2:0]       ctrl_q;
	logic [10:0]      cap_q, wr_q, count_q, unread_q, pos_q;
	logic [10:0]      wr_d, count_d, unread_d, pos_d;
	logic [31:0]      mask_q, pend_q, pend_d, div_q, ms_q;
	logic [15:0]      day_q;
	logic [7:0]       start_q, trip_q, awaddr_q, araddr_q;
	logic [31:0]      wdata_q, rd_word;
	logic [3:0]       wstrb_q;
	logic             hold_valid_q, synced;
	logic [4:0]       gidx;
	pel_pin_sync u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin_in  (time_sync_in),
		.level_q (synced)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Register write decode
	wire        wr_fire  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire [7:0]  wadr     = {awaddr_q[7:2], 2'b00};
	wire        cmd_wr   = wr_fire && wadr == PEL_CMD_ADR && wstrb_q[0];
	wire        cap_ok   = wdata_q[31:11] == 21'h0 && wdata_q[10:0] >= PEL_CAP_MIN
	                       && wdata_q[10:0] <= PEL_CAP_MAX && wstrb_q[1:0] == 2'h3;
	wire        cap_chg  = wr_fire && wadr == PEL_CAP_ADR && cap_ok
	                       && wdata_q[10:0] != cap_q;
	wire        clear    = cap_chg || (cmd_wr && wdata_q[PEL_CMD_CLEAR]);
	wire        fwd      = cmd_wr && wdata_q[PEL_CMD_FWD];
	wire        back     = cmd_wr && wdata_q[PEL_CMD_BACK];
	wire        ack      = cmd_wr && wdata_q[PEL_CMD_ACK];
	wire        ctrl_wr  = wr_fire && wadr == PEL_CTRL_ADR && wstrb_q[0];
	wire        mask_wr  = wr_fire && wadr == PEL_MASK_ADR;
	wire        tday_wr  = wr_fire && wadr == PEL_TDAY_ADR;
	wire        tms_wr   = wr_fire && wadr == PEL_TMS_ADR;
	wire        wmapped  = wadr == PEL_CTRL_ADR || wadr == PEL_CAP_ADR || wadr == PEL_MASK_ADR
	                       || wadr == PEL_CMD_ADR || tday_wr || tms_wr;
	wire [31:0] mask_d   = mask_wr ? merge(mask_q, wdata_q, wstrb_q) : mask_q;

	////////////////////////////////////////////////////////////////////////////////
	// Millisecond timestamp
	wire        tick     = div_q == 32'(CYC_PER_MS - 1);
	wire        day_end  = ms_q == PEL_MS_PER_DAY - 32'h1;
	wire [31:0] div_d    = (tick || tday_wr || tms_wr) ? 32'h0 : div_q + 32'h1;
	wire [31:0] ms_d     = tms_wr ? wdata_q : !tick ? ms_q : day_end ? 32'h0 : ms_q + 32'h1;
	wire [15:0] day_d    = tday_wr ? wdata_q[15:0] : (tick && day_end) ? day_q + 16'h1 : day_q;

	////////////////////////////////////////////////////////////////////////////////
	// Event capture
	logic [31:0] new_ev;
	for (genvar s = 0; s < PEL_STAGES; s++) begin : g_edge
		assign new_ev[s*4 + 32'(PEL_TR_SON)]  = stage_start[s] && !start_q[s];
		assign new_ev[s*4 + 32'(PEL_TR_SOFF)] = !stage_start[s] && start_q[s];
		assign new_ev[s*4 + 32'(PEL_TR_TON)]  = stage_trip[s] && !trip_q[s];
		assign new_ev[s*4 + 32'(PEL_TR_TOFF)] = !stage_trip[s] && trip_q[s];
	end
	always_comb begin
		gidx = 5'h00;
		for (int i = PEL_SRCS - 1; i >= 0; i--) begin
			if (pend_q[i]) begin
				gidx = 5'(i);
			end
		end
	end

	wire        log_en   = rd_state_q == RD_IDLE && !s_axi_arvalid;
	wire        log_fire = log_en && pend_q != 32'h0 && !clear;
	wire [31:0] grant    = log_fire ? (32'h1 << gidx) : 32'h0;
	assign      pend_d   = ((pend_q & ~grant) | new_ev) & ~mask_d;
	wire        lost     = unread_q == cap_q;

	assign new_entry.ovf    = lost;
	assign new_entry.unsync = !synced;
	assign new_entry.chan   = {5'h00, gidx[4:2]};
	assign new_entry.code   = {6'h00, gidx[1:0]};
	assign new_entry.fault  = ctrl_q[PEL_CTRL_SCALE] ? fault_pri : fault_pu;
	assign new_entry.day    = day_q;
	assign new_entry.msec   = ms_q;

	////////////////////////////////////////////////////////////////////////////////
	// Ring pointers
	wire        pop      = rd_state_q == RD_FETCH && {araddr_q[7:2], 2'b00} == PEL_NEXT_ADR
	                       && unread_q != 11'h0;
	wire [10:0] oldest   = idx_sub(wr_q, count_q, cap_q);
	wire [10:0] pop_idx  = idx_sub(wr_q, unread_q, cap_q);
	wire [10:0] loc_idx  = ctrl_q[PEL_CTRL_ORDER] ? idx_sub(wr_q, pos_q + 11'h1, cap_q)
	                       : idx_add(oldest, pos_q, cap_q);
	assign wr_d     = clear ? 11'h0 : log_fire ? idx_add(wr_q, 11'h1, cap_q) : wr_q;
	assign count_d  = clear ? 11'h0 : (log_fire && count_q != cap_q) ? count_q + 11'h1 : count_q;
	assign unread_d = clear ? 11'h0 : pop ? unread_q - 11'h1
	                  : (log_fire && !lost) ? unread_q + 11'h1 : unread_q;
	assign pos_d    = clear ? 11'h0 : (fwd && pos_q + 11'h1 < count_q) ? pos_q + 11'h1
	                  : (back && pos_q != 11'h0) ? pos_q - 11'h1 : pos_q;
	wire        popup_d  = ctrl_q[PEL_CTRL_POPUP] && (log_fire || (popup_indication && !ack));

	always_ff @(posedge aclk) begin
		if (log_fire) begin
			mem[wr_q] <= new_entry;
		end
		pop_entry_q <= mem[pop_idx];
		loc_entry_q <= mem[loc_idx];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap_q   <= PEL_CAP_RST;
			ctrl_q  <= PEL_CTRL_RST;
			mask_q  <= PEL_MASK_RST;
			{wr_q, count_q, unread_q, pos_q} <= 44'h0;
			{pend_q, div_q, ms_q, day_q} <= 112'h0;
			{start_q, trip_q} <= 16'h0;
			popup_indication <= 1'b0;
		end else begin
			cap_q   <= cap_chg ? wdata_q[10:0] : cap_q;
			ctrl_q  <= ctrl_wr ? wdata_q[2:0] : ctrl_q;
			mask_q  <= mask_d;
			{wr_q, count_q, unread_q, pos_q} <= {wr_d, count_d, unread_d, pos_d};
			{pend_q, div_q, ms_q, day_q} <= {pend_d, div_d, ms_d, day_d};
			{start_q, trip_q} <= {stage_start, stage_trip};
			popup_indication <= popup_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_q       <= '0;
			hold_valid_q <= 1'b0;
		end else if (pop) begin
			hold_q       <= pop_entry_q;
			hold_valid_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{s_axi_awready, s_axi_wready, s_axi_bvalid} <= 3'b110;
			s_axi_bresp <= PEL_RESP_OKAY;
			awaddr_q    <= 8'h00;
			wdata_q     <= 32'h0;
			wstrb_q     <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_q      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				{wdata_q, wstrb_q} <= {s_axi_wdata, s_axi_wstrb};
				s_axi_wready       <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wmapped ? PEL_RESP_OKAY : PEL_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				{s_axi_awready, s_axi_wready, s_axi_bvalid} <= 3'b110;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel
	always_comb begin
		unique case ({araddr_q[7:2], 2'b00})
			PEL_CTRL_ADR: rd_word = {29'h0, ctrl_q};
			PEL_CAP_ADR:  rd_word = {21'h0, cap_q};
			PEL_MASK_ADR: rd_word = mask_q;
			PEL_CMD_ADR:  rd_word = 32'h0;
			PEL_TDAY_ADR: rd_word = {16'h0, day_q};
			PEL_TMS_ADR:  rd_word = ms_q;
			PEL_STAT_ADR: rd_word = {synced, popup_indication, 3'h0, unread_q, 5'h0, count_q};
			PEL_NEXT_ADR: rd_word = id_word(pop_entry_q, unread_q != 11'h0);
			PEL_HID_ADR:  rd_word = id_word(hold_q, hold_valid_q);
			PEL_HDAY_ADR: rd_word = {16'h0, hold_q.day};
			PEL_HMS_ADR:  rd_word = hold_q.msec;
			PEL_HFLT_ADR: rd_word = {16'h0, hold_q.fault};
			PEL_LID_ADR:  rd_word = id_word(loc_entry_q, pos_q < count_q);
			PEL_LDAY_ADR: rd_word = {16'h0, loc_entry_q.day};
			PEL_LMS_ADR:  rd_word = loc_entry_q.msec;
			PEL_LFLT_ADR: rd_word = {16'h0, loc_entry_q.fault};
			PEL_LPOS_ADR: rd_word = {21'h0, pos_q};
			default:      rd_word = 32'h0;
		endcase
	end
	wire rmapped = {araddr_q[7:2], 2'b00} <= PEL_LPOS_ADR;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_q    <= RD_IDLE;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= PEL_RESP_OKAY;
			araddr_q      <= 8'h00;
		end else begin
			unique case (rd_state_q)
				RD_IDLE: if (s_axi_arvalid) begin
					araddr_q      <= s_axi_araddr;
					s_axi_arready <= 1'b0;
					rd_state_q    <= RD_FETCH;
				end
				RD_FETCH: begin
					s_axi_rdata  <= rd_word;
					s_axi_rresp  <= rmapped ? PEL_RESP_OKAY : PEL_RESP_SLVERR;
					s_axi_rvalid <= 1'b1;
					rd_state_q   <= RD_RESP;
				end
				RD_RESP: if (s_axi_rready) begin
					s_axi_rvalid  <= 1'b0;
					s_axi_arready <= 1'b1;
					rd_state_q    <= RD_IDLE;
				end
				default: rd_state_q <= RD_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	cap_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cap_q >= PEL_CAP_MIN && cap_q <= PEL_CAP_MAX) else $error("capacity out of range");
	cap_reset_a: assert property (@(posedge aclk)
		!$past(aresetn) && aresetn |-> cap_q == PEL_CAP_RST) else $error("capacity not 200");
	cap_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cap_chg |=> count_q == 11'h0 && unread_q == 11'h0 && cap_q == $past(wdata_q[10:0]))
		else $error("capacity change kept entries");
	full_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		log_fire && count_q == cap_q |=> count_q == $past(cap_q)) else $error("full log grew");
	mask_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
		log_fire |-> !mask_q[gidx]) else $error("masked event logged");
	ovf_mark_a: assert property (@(posedge aclk) disable iff (!aresetn)
		log_fire && unread_q == cap_q |=> unread_q == cap_q && mem[$past(wr_q)].ovf)
		else $error("overflow not marked");
	pop_adv_a: assert property (@(posedge aclk) disable iff (!aresetn)
		pop |=> unread_q == $past(unread_q) - 11'h1 && s_axi_rvalid
		&& s_axi_rdata[PEL_ID_VALID]) else $error("read did not advance");
	pop_empty_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_state_q == RD_FETCH && {araddr_q[7:2], 2'b00} == PEL_NEXT_ADR && unread_q == 11'h0
		|=> unread_q == 11'h0 && !s_axi_rdata[PEL_ID_VALID]) else $error("empty read advanced");
	browse_fwd_a: assert property (@(posedge aclk) disable iff (!aresetn)
		fwd && !clear && pos_q + 11'h1 < count_q |=> pos_q == $past(pos_q) + 11'h1
		&& unread_q == $past(unread_d)) else $error("browse step wrong");
endmodule : pel_event_log

// *** hw/pel_pin_sync.sv ***
`timescale 1ns/10ps
module pel_pin_sync (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic pin_in,
	output logic      level_q
);
	logic [2:0] stage_q;

	// Three stages; level moves once the last two agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage_q <= 3'h0;
			level_q <= 1'b0;
		end else begin
			stage_q <= {stage_q[1:0], pin_in};
			if (stage_q[1] == stage_q[2]) begin
				level_q <= stage_q[2];
			end
		end
	end
endmodule : pel_pin_sync

// *** hw/pel_pkg.sv ***
package pel_pkg;

	// Bus
	localparam int unsigned AXI_AW          = 8;
	localparam logic [1:0]  PEL_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  PEL_RESP_SLVERR = 2'h2;

	// Register byte addresses
	localparam logic [7:0] PEL_CTRL_ADR   = 8'h00;
	localparam logic [7:0] PEL_CAP_ADR    = 8'h04;
	localparam logic [7:0] PEL_MASK_ADR   = 8'h08;
	localparam logic [7:0] PEL_CMD_ADR    = 8'h0C;
	localparam logic [7:0] PEL_TDAY_ADR   = 8'h10;
	localparam logic [7:0] PEL_TMS_ADR    = 8'h14;
	localparam logic [7:0] PEL_STAT_ADR   = 8'h18;
	localparam logic [7:0] PEL_NEXT_ADR   = 8'h1C;
	localparam logic [7:0] PEL_HID_ADR    = 8'h20;
	localparam logic [7:0] PEL_HDAY_ADR   = 8'h24;
	localparam logic [7:0] PEL_HMS_ADR    = 8'h28;
	localparam logic [7:0] PEL_HFLT_ADR   = 8'h2C;
	localparam logic [7:0] PEL_LID_ADR    = 8'h30;
	localparam logic [7:0] PEL_LDAY_ADR   = 8'h34;
	localparam logic [7:0] PEL_LMS_ADR    = 8'h38;
	localparam logic [7:0] PEL_LFLT_ADR   = 8'h3C;
	localparam logic [7:0] PEL_LPOS_ADR   = 8'h40;

	// Control and command fields
	localparam int unsigned PEL_CTRL_ORDER = 0;
	localparam int unsigned PEL_CTRL_SCALE = 1;
	localparam int unsigned PEL_CTRL_POPUP = 2;
	localparam logic [2:0]  PEL_CTRL_RST   = 3'h0;
	localparam int unsigned PEL_CMD_CLEAR  = 0;
	localparam int unsigned PEL_CMD_FWD    = 1;
	localparam int unsigned PEL_CMD_BACK   = 2;
	localparam int unsigned PEL_CMD_ACK    = 3;

	// Identifier word fields
	localparam int unsigned PEL_ID_VALID  = 31;
	localparam int unsigned PEL_ID_OVF    = 30;
	localparam int unsigned PEL_ID_UNSYNC = 29;
	localparam int unsigned PEL_ID_SHOWCH = 28;

	// Status fields
	localparam int unsigned PEL_ST_UNREAD = 16;
	localparam int unsigned PEL_ST_POPUP  = 30;
	localparam int unsigned PEL_ST_SYNC   = 31;

	// Capacity
	localparam int unsigned PEL_CAP_W     = 11;
	localparam int unsigned PEL_DEPTH     = 2000;
	localparam logic [10:0] PEL_CAP_RST   = 11'h0C8;
	localparam logic [10:0] PEL_CAP_MIN   = 11'h032;
	localparam logic [10:0] PEL_CAP_MAX   = 11'h7D0;
	localparam logic [31:0] PEL_MASK_RST  = 32'h0000_0000;

	// Sources: four transitions per stage
	localparam int unsigned PEL_STAGES    = 8;
	localparam int unsigned PEL_SRCS      = 32;
	localparam logic [1:0]  PEL_TR_SON    = 2'h0;
	localparam logic [1:0]  PEL_TR_SOFF   = 2'h1;
	localparam logic [1:0]  PEL_TR_TON    = 2'h2;
	localparam logic [1:0]  PEL_TR_TOFF   = 2'h3;

	// Timing
	localparam int unsigned PEL_CLK_HZ     = 32'h0098_9680;
	localparam int unsigned PEL_TICK_MS    = 32'h0000_0001;
	localparam int unsigned PEL_CYC_PER_MS = PEL_CLK_HZ / 32'h0000_03E8 * PEL_TICK_MS;
	localparam logic [31:0] PEL_MS_PER_DAY = 32'h0526_5C00;

	typedef struct packed {
		logic        ovf;
		logic        unsync;
		logic [7:0]  chan;
		logic [7:0]  code;
		logic [15:0] fault;
		logic [15:0] day;
		logic [31:0] msec;
	} pel_entry_type;

	typedef enum logic [1:0] {
		RD_IDLE  = 2'b00,
		RD_FETCH = 2'b01,
		RD_RESP  = 2'b10
	} pel_rd_state_type;

endpackage : pel_pkg

// *** testbench/pel_station.sv ***
`timescale 1ns/10ps
module pel_station import pel_pkg::*; (
	input  wire logic              aclk,
	output logic                   s_axi_awvalid,
	input  wire logic              s_axi_awready,
	output logic [AXI_AW-1:0]      s_axi_awaddr,
	output logic [2:0]             s_axi_awprot,
	output logic                   s_axi_wvalid,
	input  wire logic              s_axi_wready,
	output logic [31:0]            s_axi_wdata,
	output logic [3:0]             s_axi_wstrb,
	input  wire logic              s_axi_bvalid,
	output logic                   s_axi_bready,
	input  wire logic [1:0]        s_axi_bresp,
	output logic                   s_axi_arvalid,
	input  wire logic              s_axi_arready,
	output logic [AXI_AW-1:0]      s_axi_araddr,
	output logic [2:0]             s_axi_arprot,
	input  wire logic              s_axi_rvalid,
	output logic                   s_axi_rready,
	input  wire logic [31:0]       s_axi_rdata,
	input  wire logic [1:0]        s_axi_rresp
);
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
		s_axi_awprot = 3'h0;
		s_axi_arprot = 3'h0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Single write, payload inverted once taken
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask : wr
	////////////////////////////////////////////////////////////////////////////////
	// Single read, address inverted once taken
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~a;
			end
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask : rd
endmodule : pel_station

// *** testbench/protection_event_log_tb.sv ***
`timescale 1ns/10ps
module protection_event_log_tb import pel_pkg::*;;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, time_sync_in, popup_indication;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, stage_start, stage_trip, seed;
	logic [2:0]  s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [15:0] fault_pu, fault_pri;
	int          errors, num_checks, cycles, s;
	localparam logic [31:0] M = 32'hF000_FFFF;
	localparam logic [7:0]  ORD = {PEL_TR_SOFF, PEL_TR_TOFF, PEL_TR_TON, PEL_TR_SON};

	pel_event_log #(.CYC_PER_MS(10)) dut (.*);
	pel_station sta (.*);

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	function logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : lfsr
	function logic [31:0] idw(input logic [7:0] ch, input logic [7:0] c, input logic o,
			input logic u);
		return {1'b1, o, u, ch != 8'h00, 12'h000, ch, c};
	endfunction : idw
	task end_of_test;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		sta.rd(a, d, r);
		chk({30'h0, r}, {30'h0, (a > 8'h40) ? PEL_RESP_SLVERR : PEL_RESP_OKAY});
		chk(d & m, e);
	endtask : rc
	task w(input logic [7:0] a, input logic [31:0] v);
		sta.wr(a, v, 4'hF, r);
		chk({30'h0, r}, {30'h0, (a > 8'h40) ? PEL_RESP_SLVERR : PEL_RESP_OKAY});
	endtask : w
	task ev(input int i, input logic t, input logic v);
		@(posedge aclk);
		if (t)
			stage_trip[i] <= v;
		else
			stage_start[i] <= v;
		repeat (4) @(posedge aclk);
	endtask : ev
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("[FAIL] %0t timeout", $time);
			end_of_test();
		end
	end

	initial begin
		aresetn = 1'b0;
		{stage_start, stage_trip, fault_pu, fault_pri} = 48'h0;
		time_sync_in = 1'b0;
		seed = 8'h5C;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset values and unmapped place
		rc(PEL_CTRL_ADR, 32'h7, 32'h0);
		rc(PEL_CAP_ADR, 32'h7FF, 32'd200);
		rc(PEL_MASK_ADR, 32'hFFFF_FFFF, PEL_MASK_RST);
		rc(PEL_STAT_ADR, 32'h7FF, 32'h0);
		rc(8'h44, 32'hFFFF_FFFF, 32'h0);
		w(8'h44, 32'h1);
		// First event unsynchronized, popup disabled
		fault_pu <= 16'h1A5C;
		ev(0, 1'b0, 1'b1);
		chk({31'h0, popup_indication}, 32'h0);
		rc(PEL_STAT_ADR, 32'h7FF, 32'h1);
		rc(PEL_NEXT_ADR, M, idw(0, 0, 0, 1));
		rc(PEL_NEXT_ADR, 32'h8000_0000, 32'h0);
		rc(PEL_HID_ADR, M, idw(0, 0, 0, 1));
		rc(PEL_HID_ADR, M, idw(0, 0, 0, 1));
		rc(PEL_HFLT_ADR, 32'hFFFF, 32'h1A5C);
		// Synchronized time, timestamp after 10 ms
		time_sync_in <= 1'b1;
		w(PEL_TDAY_ADR, 32'h5);
		w(PEL_TMS_ADR, 32'h0);
		repeat (100) @(posedge aclk);
		ev(0, 1'b1, 1'b1);
		rc(PEL_STAT_ADR, 32'h8000_0000, 32'h8000_0000);
		rc(PEL_NEXT_ADR, M, idw(0, 2, 0, 0));
		rc(PEL_HDAY_ADR, 32'hFFFF, 32'h5);
		sta.rd(PEL_HMS_ADR, d, r);
		chk({31'h0, d >= 32'd10 && d <= 32'd11}, 32'h1);
		ev(0, 1'b1, 1'b0);
		ev(0, 1'b0, 1'b0);
		w(PEL_CMD_ADR, 32'h1);
		rc(PEL_STAT_ADR, 32'h07FF_07FF, 32'h0);
		// Random stages, all transitions, primary scaling, popup
		w(PEL_CTRL_ADR, 32'h6);
		repeat (4) begin
			seed = lfsr(seed);
			s = seed[7:5];
			fault_pri <= {seed, ~seed};
			ev(s, 1'b0, 1'b1);
			ev(s, 1'b1, 1'b1);
			ev(s, 1'b1, 1'b0);
			ev(s, 1'b0, 1'b0);
			for (int k = 0; k < 4; k++) begin
				rc(PEL_NEXT_ADR, M, idw(s, {6'h00, ORD[k*2 +: 2]}, 0, 0));
				rc(PEL_HFLT_ADR, 32'hFFFF, {16'h0, seed, ~seed});
			end
		end
		chk({31'h0, popup_indication}, 32'h1);
		w(PEL_CMD_ADR, 32'h8);
		chk({31'h0, popup_indication}, 32'h0);
		// Masked start-on never logged
		w(PEL_MASK_ADR, 32'h1 << (s * 4));
		ev(s, 1'b0, 1'b1);
		ev(s, 1'b1, 1'b1);
		rc(PEL_STAT_ADR, 32'h7FF, 32'd17);
		ev(s, 1'b1, 1'b0);
		ev(s, 1'b0, 1'b0);
		rc(PEL_STAT_ADR, 32'h7FF, 32'd19);
		w(PEL_MASK_ADR, 32'h0);
		// Capacity limits and change
		w(PEL_CAP_ADR, 32'd49);
		rc(PEL_CAP_ADR, 32'h7FF, 32'd200);
		w(PEL_CAP_ADR, 32'd2001);
		rc(PEL_CAP_ADR, 32'h7FF, 32'd200);
		w(PEL_CAP_ADR, 32'd2000);
		rc(PEL_CAP_ADR, 32'h7FF, 32'd2000);
		w(PEL_CAP_ADR, 32'd50);
		rc(PEL_STAT_ADR, 32'h07FF_07FF, 32'h0);
		// Overflow with no polling
		for (int i = 0; i < 51; i++)
			ev(1, 1'b0, ~i[0]);
		rc(PEL_STAT_ADR, 32'h07FF_07FF, 32'h0032_0032);
		rc(PEL_LID_ADR, M, idw(1, 1, 0, 0));
		w(PEL_CMD_ADR, 32'h2);
		rc(PEL_LID_ADR, M, idw(1, 0, 0, 0));
		rc(PEL_LPOS_ADR, 32'h7FF, 32'h1);
		w(PEL_CMD_ADR, 32'h4);
		rc(PEL_LPOS_ADR, 32'h7FF, 32'h0);
		w(PEL_CTRL_ADR, 32'h1);
		rc(PEL_LID_ADR, M, idw(1, 0, 1, 0));
		for (int i = 0; i < 50; i++) begin
			sta.rd(PEL_NEXT_ADR, d, r);
			if (i == 0)
				chk(d & M, idw(1, 1, 0, 0));
			if (i == 49)
				chk(d & M, idw(1, 0, 1, 0));
		end
		rc(PEL_NEXT_ADR, 32'h8000_0000, 32'h0);
		rc(PEL_HID_ADR, M, idw(1, 0, 1, 0));
		end_of_test();
	end
endmodule : protection_event_log_tb
